// File: verilog/rtc_pkg.sv
// Shared constants of the real-time clock core
package rtc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    typedef logic [DATA_W-1:0] byte_type;
    // Time array indices, also the register offsets 00..06
    localparam logic [2:0] T_SEC = 3'h0;
    localparam logic [2:0] T_MIN = 3'h1;
    localparam logic [2:0] T_HOUR = 3'h2;
    localparam logic [2:0] T_DAY = 3'h3;
    localparam logic [2:0] T_MONTH = 3'h4;
    localparam logic [2:0] T_YEAR = 3'h5;
    localparam logic [2:0] T_WDAY = 3'h6;
    localparam logic [7:0] A_WDAY = 8'h06;
    localparam logic [7:0] A_CTRL = 8'h07;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_MASK = 8'h09;
    localparam logic [7:0] A_VDD_TRIP = 8'h0a;
    localparam logic [7:0] A_BAT_TRIP = 8'h0b;
    localparam logic [7:0] A_TEMP_LO = 8'h0c;
    localparam logic [7:0] A_TEMP_HI = 8'h0d;
    localparam logic [7:0] A_BUS_STARTS = 8'h0e;
    // Blocks of eight, low three address bits index the entry
    localparam logic [4:0] B_ALARM = 5'h02;
    localparam logic [4:0] B_DST = 5'h03;
    localparam logic [4:0] B_TS_TO_BAT = 5'h04;
    localparam logic [4:0] B_TS_TO_VDD = 5'h05;
    localparam int ALARM_N = 4;
    localparam int DST_N = 6;
    localparam int TS_N = 6;
    localparam int SRAM_DEPTH = 128;
    // Control register fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_SEL_W = 4;
    localparam int CTRL_ALM_EN = 4;
    localparam int CTRL_ALM_REPEAT = 5;
    localparam int CTRL_DST_EN = 6;
    localparam byte_type CTRL_RESET = 8'h01;
    localparam logic [3:0] SEL_IRQ = 4'h0;
    localparam logic [3:0] SEL_OSC = 4'h1;
    // Status bits
    localparam int ST_ALARM = 0;
    localparam int ST_VDD_FAIL = 1;
    localparam int ST_BAT_LOW = 2;
    localparam int ST_TO_BAT = 3;
    localparam int ST_TO_VDD = 4;
    localparam int ST_W = 5;
    localparam int ALM_EN_BIT = 7;
    localparam byte_type DAY_RESET = 8'h01;
    localparam byte_type MONTH_RESET = 8'h01;
    localparam int OSC_DIV_W = 15;
endpackage : rtc_pkg

// File: verilog/fout_if.sv
// Oscillator divider hookup between core and divider
`timescale 1ns/1ps
interface fout_if;
    logic osc_rise;
    logic osc_lvl;
    logic [3:0] sel;
    logic sec_tick;
    logic fout;
    modport div (input osc_rise, input osc_lvl, input sel,
                 output sec_tick, output fout);
    modport core (output osc_rise, output osc_lvl, output sel,
                  input sec_tick, input fout);
endinterface : fout_if

// File: verilog/sync2.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : sync2

// File: verilog/fout_div.sv
// Oscillator divider: seconds tick and selectable output
`timescale 1ns/1ps
module fout_div (
    input wire logic clk,
    input wire logic rst_n,
    fout_if.div bus
);
    logic [rtc_pkg::OSC_DIV_W-1:0] cnt_q;
    logic [3:0] bit_idx;

    assign bit_idx = bus.sel - 4'h2;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (bus.osc_rise) begin
            cnt_q <= cnt_q + 15'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.sec_tick <= 1'b0;
        end else begin
            bus.sec_tick <= bus.osc_rise && (&cnt_q);
        end
    end

    // Every output frequency but the raw oscillator is a tap of the same counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.fout <= 1'b1;
        end else if (bus.sel == rtc_pkg::SEL_IRQ) begin
            bus.fout <= 1'b1;
        end else if (bus.sel == rtc_pkg::SEL_OSC) begin
            bus.fout <= bus.osc_lvl;
        end else begin
            bus.fout <= cnt_q[bit_idx];
        end
    end
endmodule : fout_div

// File: verilog/rtc_core.sv
// Real-time clock core with calendar, alarm, monitors and user memory
`timescale 1ns/1ps
module rtc_core (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic osc_clk,
    input wire logic on_backup,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_n,
    output logic alarm_or_clock_out_pin_oe_n,
    output logic irq,
    input wire logic [7:0] vdd_level,
    input wire logic [7:0] bat_level,
    input wire logic [9:0] temp_code
);
    localparam int SW = 30;

    logic [1:0] rst_pipe_q;
    logic rst_sync_n;
    logic [SW-1:0] raw;
    logic [SW-1:0] syn;
    logic osc_s;
    logic bkp_s;
    logic scl_s;
    logic sda_s;
    logic [7:0] vdd_s;
    logic [7:0] bat_s;
    logic [9:0] temp_s;
    logic osc_prev_q;
    logic bkp_prev_q;
    logic sda_prev_q;
    logic host_wr;
    logic host_rd;
    logic to_bat;
    logic to_vdd;
    logic tick_d1_q;
    rtc_pkg::byte_type time_q [0:6];
    rtc_pkg::byte_type time_d [0:6];
    rtc_pkg::byte_type alarm_q [0:rtc_pkg::ALARM_N-1];
    rtc_pkg::byte_type dst_q [0:rtc_pkg::DST_N-1];
    rtc_pkg::byte_type ts_bat_q [0:rtc_pkg::TS_N-1];
    rtc_pkg::byte_type ts_vdd_q [0:rtc_pkg::TS_N-1];
    rtc_pkg::byte_type sram_q [0:rtc_pkg::SRAM_DEPTH-1];
    rtc_pkg::byte_type ctrl_q;
    rtc_pkg::byte_type vdd_trip_q;
    rtc_pkg::byte_type bat_trip_q;
    rtc_pkg::byte_type bus_starts_q;
    logic [rtc_pkg::ST_W-1:0] stat_q;
    logic [rtc_pkg::ST_W-1:0] stat_d;
    logic [rtc_pkg::ST_W-1:0] mask_q;
    logic [rtc_pkg::ST_W-1:0] set_vec;
    logic [rtc_pkg::ST_W-1:0] clr_vec;
    logic dst_active_q;
    logic dst_active_d;
    logic alarm_hit;
    logic vdd_low_q;
    logic bat_low_q;
    logic vdd_low;
    logic bat_low;
    logic in_time;
    logic [4:0] blk;
    logic [2:0] idx;

    fout_if fo ();

    function automatic rtc_pkg::byte_type days_in_month(
        input rtc_pkg::byte_type m, input rtc_pkg::byte_type y);
        rtc_pkg::byte_type n;
        n = 8'h1f;
        if (m == 8'h02) begin
            // Years 2000..2099: every fourth year is a leap year
            n = (y[1:0] == 2'h0) ? 8'h1d : 8'h1c;
        end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 ||
                     m == 8'h0b) begin
            n = 8'h1e;
        end
        return n;
    endfunction : days_in_month

    function automatic logic field_ok(input rtc_pkg::byte_type a,
                                      input rtc_pkg::byte_type t);
        return !a[rtc_pkg::ALM_EN_BIT] || (a[6:0] == t[6:0]);
    endfunction : field_ok

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_q[1];

    // Multi-bit levels change slowly; a torn sample lasts one cycle
    assign raw = {temp_code, bat_level, vdd_level, sda_in, scl_in,
                  on_backup, osc_clk};

    sync2 #(.W(SW)) u_sync (
        .clk(clk_sys),
        .rst_n(rst_sync_n),
        .d(raw),
        .q(syn)
    );

    assign osc_s = syn[0];
    assign bkp_s = syn[1];
    assign scl_s = syn[2];
    assign sda_s = syn[3];
    assign vdd_s = syn[11:4];
    assign bat_s = syn[19:12];
    assign temp_s = syn[29:20];

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            osc_prev_q <= 1'b0;
            bkp_prev_q <= 1'b0;
            sda_prev_q <= 1'b1;
            tick_d1_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_s;
            bkp_prev_q <= bkp_s;
            sda_prev_q <= sda_s;
            tick_d1_q <= fo.sec_tick;
        end
    end

    assign to_bat = bkp_s && !bkp_prev_q;
    assign to_vdd = !bkp_s && bkp_prev_q;
    // Host path is dead on backup supply
    assign host_wr = wr && !bkp_s;
    assign host_rd = rd && !bkp_s;
    assign blk = addr[7:3];
    assign idx = addr[2:0];
    assign in_time = (addr <= rtc_pkg::A_WDAY);

    assign fo.osc_rise = osc_s && !osc_prev_q;
    assign fo.osc_lvl = osc_s;
    assign fo.sel = ctrl_q[rtc_pkg::CTRL_SEL_LSB +: rtc_pkg::CTRL_SEL_W];

    fout_div u_div (
        .clk(clk_sys),
        .rst_n(rst_sync_n),
        .bus(fo.div)
    );

    // Calendar advance, then host writes override one field
    always_comb begin
        time_d = time_q;
        dst_active_d = dst_active_q;
        if (fo.sec_tick) begin
            if (time_q[rtc_pkg::T_SEC] != 8'h3b) begin
                time_d[rtc_pkg::T_SEC] =
                    time_q[rtc_pkg::T_SEC] + 8'h01;
            end else begin
                time_d[rtc_pkg::T_SEC] = 8'h00;
                if (time_q[rtc_pkg::T_MIN] != 8'h3b) begin
                    time_d[rtc_pkg::T_MIN] = time_q[rtc_pkg::T_MIN] + 8'h01;
                end else begin
                    time_d[rtc_pkg::T_MIN] = 8'h00;
                    if (time_q[rtc_pkg::T_HOUR] != 8'h17) begin
                        time_d[rtc_pkg::T_HOUR] =
                            time_q[rtc_pkg::T_HOUR] + 8'h01;
                        // Forward shift cannot land past 23:00
                        if (ctrl_q[rtc_pkg::CTRL_DST_EN] && !dst_active_q &&
                            time_q[rtc_pkg::T_MONTH] == dst_q[0] &&
                            time_q[rtc_pkg::T_DAY] == dst_q[1] &&
                            time_d[rtc_pkg::T_HOUR] == dst_q[2] &&
                            time_d[rtc_pkg::T_HOUR] != 8'h17) begin
                            time_d[rtc_pkg::T_HOUR] =
                                time_q[rtc_pkg::T_HOUR] + 8'h02;
                            dst_active_d = 1'b1;
                        end else if (ctrl_q[rtc_pkg::CTRL_DST_EN] &&
                            dst_active_q &&
                            time_q[rtc_pkg::T_MONTH] == dst_q[3] &&
                            time_q[rtc_pkg::T_DAY] == dst_q[4] &&
                            time_d[rtc_pkg::T_HOUR] == dst_q[5]) begin
                            time_d[rtc_pkg::T_HOUR] =
                                time_q[rtc_pkg::T_HOUR];
                            dst_active_d = 1'b0;
                        end
                    end else begin
                        time_d[rtc_pkg::T_HOUR] = 8'h00;
                        time_d[rtc_pkg::T_WDAY] =
                            (time_q[rtc_pkg::T_WDAY] == 8'h06) ? 8'h00 :
                            time_q[rtc_pkg::T_WDAY] + 8'h01;
                        if (time_q[rtc_pkg::T_DAY] !=
                            days_in_month(time_q[rtc_pkg::T_MONTH],
                                          time_q[rtc_pkg::T_YEAR])) begin
                            time_d[rtc_pkg::T_DAY] =
                                time_q[rtc_pkg::T_DAY] + 8'h01;
                        end else begin
                            time_d[rtc_pkg::T_DAY] = 8'h01;
                            if (time_q[rtc_pkg::T_MONTH] != 8'h0c) begin
                                time_d[rtc_pkg::T_MONTH] =
                                    time_q[rtc_pkg::T_MONTH] + 8'h01;
                            end else begin
                                time_d[rtc_pkg::T_MONTH] = 8'h01;
                                time_d[rtc_pkg::T_YEAR] =
                                    (time_q[rtc_pkg::T_YEAR] == 8'h63) ?
                                    8'h00 : time_q[rtc_pkg::T_YEAR] + 8'h01;
                            end
                        end
                    end
                end
            end
        end
        if (host_wr && in_time) begin
            time_d[idx] = wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < 7; i++) begin
                time_q[i] <= 8'h00;
            end
            time_q[rtc_pkg::T_DAY] <= rtc_pkg::DAY_RESET;
            time_q[rtc_pkg::T_MONTH] <= rtc_pkg::MONTH_RESET;
            dst_active_q <= 1'b0;
        end else begin
            time_q <= time_d;
            dst_active_q <= dst_active_d;
        end
    end

    // Host-written settings
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mask_q <= '0;
            vdd_trip_q <= 8'h00;
            bat_trip_q <= 8'h00;
            for (int i = 0; i < rtc_pkg::ALARM_N; i++) begin
                alarm_q[i] <= 8'h00;
            end
            for (int i = 0; i < rtc_pkg::DST_N; i++) begin
                dst_q[i] <= 8'h00;
            end
        end else if (host_wr) begin
            if (addr == rtc_pkg::A_MASK) begin
                mask_q <= wdata[rtc_pkg::ST_W-1:0];
            end else if (addr == rtc_pkg::A_VDD_TRIP) begin
                vdd_trip_q <= wdata;
            end else if (addr == rtc_pkg::A_BAT_TRIP) begin
                bat_trip_q <= wdata;
            end else if (blk == rtc_pkg::B_ALARM &&
                         idx < 3'(rtc_pkg::ALARM_N)) begin
                alarm_q[idx[1:0]] <= wdata;
            end else if (blk == rtc_pkg::B_DST &&
                         idx < 3'(rtc_pkg::DST_N)) begin
                dst_q[idx] <= wdata;
            end
        end
    end

    // Selected frequency defaults to the raw oscillator
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_q <= rtc_pkg::CTRL_RESET;
        end else begin
            if (host_wr && addr == rtc_pkg::A_CTRL) begin
                ctrl_q <= wdata;
            end
            // A one-time alarm disarms itself once it fires
            if (alarm_hit && !ctrl_q[rtc_pkg::CTRL_ALM_REPEAT]) begin
                ctrl_q[rtc_pkg::CTRL_ALM_EN] <= 1'b0;
            end
        end
    end

    // Alarm compared one cycle after the time has advanced
    assign alarm_hit = tick_d1_q && ctrl_q[rtc_pkg::CTRL_ALM_EN] &&
        field_ok(alarm_q[0], time_q[rtc_pkg::T_SEC]) &&
        field_ok(alarm_q[1], time_q[rtc_pkg::T_MIN]) &&
        field_ok(alarm_q[2], time_q[rtc_pkg::T_HOUR]) &&
        field_ok(alarm_q[3], time_q[rtc_pkg::T_DAY]);

    assign vdd_low = vdd_s < vdd_trip_q;
    assign bat_low = bat_s < bat_trip_q;

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            vdd_low_q <= 1'b0;
            bat_low_q <= 1'b0;
        end else begin
            vdd_low_q <= vdd_low;
            bat_low_q <= bat_low;
        end
    end

    always_comb begin
        set_vec = '0;
        set_vec[rtc_pkg::ST_ALARM] = alarm_hit;
        set_vec[rtc_pkg::ST_VDD_FAIL] = vdd_low && !vdd_low_q;
        set_vec[rtc_pkg::ST_BAT_LOW] = bat_low && !bat_low_q;
        set_vec[rtc_pkg::ST_TO_BAT] = to_bat;
        set_vec[rtc_pkg::ST_TO_VDD] = to_vdd;
        clr_vec = '0;
        if (host_wr && addr == rtc_pkg::A_STAT) begin
            clr_vec = wdata[rtc_pkg::ST_W-1:0];
        end
        // A new event outlasts a clear in the same cycle
        stat_d = (stat_q & ~clr_vec) | set_vec;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stat_q <= '0;
            irq <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq <= |(stat_d & mask_q);
        end
    end

    // Mode follows the frequency select field
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            alarm_or_clock_out_pin_oe_n <= 1'b1;
        end else if (fo.sel == rtc_pkg::SEL_IRQ) begin
            alarm_or_clock_out_pin_oe_n <= !irq;
        end else begin
            alarm_or_clock_out_pin_oe_n <= fo.fout;
        end
    end

    // Supply switchover time stamps, weekday not kept
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < rtc_pkg::TS_N; i++) begin
                ts_bat_q[i] <= 8'h00;
                ts_vdd_q[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < rtc_pkg::TS_N; i++) begin
                if (to_bat) begin
                    ts_bat_q[i] <= time_q[i];
                end
                if (to_vdd) begin
                    ts_vdd_q[i] <= time_q[i];
                end
            end
        end
    end

    // Start conditions seen on the serial pins, main power only
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bus_starts_q <= 8'h00;
            sda_oe_n <= 1'b1;
        end else begin
            if (!bkp_s && scl_s && sda_prev_q && !sda_s) begin
                bus_starts_q <= bus_starts_q + 8'h01;
            end
            sda_oe_n <= 1'b1;
        end
    end

    // User memory has no reset so it survives supply changes
    always_ff @(posedge clk_sys) begin
        if (host_wr && addr[7]) begin
            sram_q[addr[6:0]] <= wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata <= 8'h00;
        end else if (!host_rd) begin
            rdata <= 8'h00;
        end else if (addr[7]) begin
            rdata <= sram_q[addr[6:0]];
        end else if (in_time) begin
            rdata <= time_q[idx];
        end else if (addr == rtc_pkg::A_CTRL) begin
            rdata <= ctrl_q;
        end else if (addr == rtc_pkg::A_STAT) begin
            rdata <= 8'(stat_q);
        end else if (addr == rtc_pkg::A_MASK) begin
            rdata <= 8'(mask_q);
        end else if (addr == rtc_pkg::A_VDD_TRIP) begin
            rdata <= vdd_trip_q;
        end else if (addr == rtc_pkg::A_BAT_TRIP) begin
            rdata <= bat_trip_q;
        end else if (addr == rtc_pkg::A_TEMP_LO) begin
            rdata <= temp_s[7:0];
        end else if (addr == rtc_pkg::A_TEMP_HI) begin
            rdata <= {6'h00, temp_s[9:8]};
        end else if (addr == rtc_pkg::A_BUS_STARTS) begin
            rdata <= bus_starts_q;
        end else if (blk == rtc_pkg::B_ALARM &&
                     idx < 3'(rtc_pkg::ALARM_N)) begin
            rdata <= alarm_q[idx[1:0]];
        end else if (blk == rtc_pkg::B_DST && idx < 3'(rtc_pkg::DST_N)) begin
            rdata <= dst_q[idx];
        end else if (blk == rtc_pkg::B_TS_TO_BAT &&
                     idx < 3'(rtc_pkg::TS_N)) begin
            rdata <= ts_bat_q[idx];
        end else if (blk == rtc_pkg::B_TS_TO_VDD &&
                     idx < 3'(rtc_pkg::TS_N)) begin
            rdata <= ts_vdd_q[idx];
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule : rtc_core

// File: test/i2c_host.sv
// Serial bus host model issuing start and stop conditions
`timescale 1ns/1ps
module i2c_host (
    input wire logic go,
    output logic scl,
    output logic sda
);
    // Released lines float high through the pull-ups
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    always @(posedge go) begin
        #1250 sda = 1'b0;
        #1250 scl = 1'b0;
        #2500 scl = 1'b1;
        #1250 sda = 1'b1;
    end
endmodule : i2c_host

// File: test/rtc_core_sva.sv
// Assertion checker for the real-time clock core pins
`timescale 1ns/1ps
module rtc_core_sva (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic on_backup,
    input wire logic sda_oe_n,
    input wire logic alarm_or_clock_out_pin_oe_n,
    input wire logic irq,
    input wire logic [9:0] temp_code
);
    logic [3:0] sel_q;
    logic [5:0] age_q;
    wire logic pin = alarm_or_clock_out_pin_oe_n;
    // Age gate hides the divider phase jump after a select change
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= 4'h1;
            age_q <= 6'h00;
        end else if (wr && addr == rtc_pkg::A_CTRL && !on_backup) begin
            sel_q <= wdata[3:0];
            age_q <= 6'h00;
        end else if (age_q != 6'h3f) begin
            age_q <= age_q + 6'h01;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_sda_released: assert property (sda_oe_n)
        else $error("serial data driven");
    chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero");
    chk_backup_read: assert property (
        on_backup[*4] ##0 rd |=> rdata == 8'h00)
        else $error("read answered on backup");
    chk_temp_low: assert property (
        ($stable(temp_code) && !on_backup)[*4]
        ##0 rd && addr == rtc_pkg::A_TEMP_LO |=>
        rdata == temp_code[7:0] || $changed(temp_code))
        else $error("temperature low byte wrong");
    chk_irq_pulls: assert property (
        age_q > 6'h28 && sel_q == 4'h0 && irq |=> !pin)
        else $error("pin not pulled");
    chk_irq_release: assert property (
        age_q > 6'h28 && sel_q == 4'h0 && !irq |=> pin)
        else $error("pin not released");
    chk_osc_default: assert property (
        age_q == 6'h3f && sel_q == 4'h1 |-> ##[1:12] $changed(pin))
        else $error("no clock out");
    chk_div_level: assert property (
        age_q == 6'h3f && sel_q == 4'h2 && $changed(pin) |=>
        $stable(pin)[*5])
        else $error("divided level too short");
    cover property (sel_q == 4'h0 && irq);
    cover property (on_backup && rd);
    cover property (sel_q == 4'h2 && $changed(pin));
endmodule : rtc_core_sva
bind rtc_core rtc_core_sva rtc_core_sva_inst (.clk_sys, .rst_n, .addr,
    .wdata, .wr, .rd, .rdata, .on_backup, .sda_oe_n,
    .alarm_or_clock_out_pin_oe_n, .irq, .temp_code);

// File: test/rtc_core_tb.sv
// Self-checking bench for the real-time clock core
`timescale 1ns/1ps
module rtc_core_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic osc_clk = 1'b0;
    logic on_backup = 1'b0;
    logic go = 1'b0;
    logic [7:0] vdd_level = 8'hff;
    logic [9:0] temp_code = 10'h000;
    logic [7:0] rdata;
    logic scl, sda, sda_oe_n, pin_oe_n, irq;
    int num_errors = 0;
    int tests_run = 0;
    rtc_core rtc_core_inst (.clk_sys, .rst_n, .addr, .wdata, .wr, .rd,
        .rdata, .osc_clk, .on_backup, .scl_in(scl),
        .sda_in(sda & sda_oe_n), .sda_oe_n,
        .alarm_or_clock_out_pin_oe_n(pin_oe_n), .irq, .vdd_level,
        .bat_level(8'hff), .temp_code);
    i2c_host i2c_host_inst (.go, .scl, .sda);
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    // Odd offset keeps the oscillator clock out of phase with clk_sys
    initial begin
        #37;
        forever #200 osc_clk = ~osc_clk;
    end
    task automatic check(input string n, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, e);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 check($sformatf("reg %h", a), e, rdata);
    endtask : rd_chk
    task automatic count_edges(input int n, output int c);
        logic p;
        c = 0;
        p = pin_oe_n;
        repeat (n) begin
            @(posedge clk_sys);
            #1 if (pin_oe_n !== p) c++;
            p = pin_oe_n;
        end
    endtask : count_edges
    task automatic pins(input logic i, p);
        repeat (8) @(posedge clk_sys);
        #1 check("irq", 8'(i), 8'(irq));
        check("pin_oe_n", 8'(p), 8'(pin_oe_n));
    endtask : pins
    task automatic t_reset;
        int c;
        rd_chk(rtc_pkg::A_CTRL, rtc_pkg::CTRL_RESET);
        count_edges(40, c);
        check("toggles", 8'h01, 8'(c >= 9 && c <= 11));
        check("sda_oe_n", 8'h01, 8'(sda_oe_n));
    endtask : t_reset
    task automatic t_regs;
        wr_reg(8'h00, 8'h12);
        wr_reg(8'h01, 8'h34);
        wr_reg(8'h02, 8'h05);
        wr_reg(8'h80, 8'ha5);
        wr_reg(8'hff, 8'h5a);
        wr_reg(8'h0f, 8'hff);
        rd_chk(8'h00, 8'h12);
        rd_chk(8'h01, 8'h34);
        rd_chk(8'h02, 8'h05);
        rd_chk(8'h80, 8'ha5);
        rd_chk(8'hff, 8'h5a);
        rd_chk(8'h0f, 8'h00);
        @(posedge clk_sys);
        temp_code <= 10'h2a5;
        repeat (4) @(posedge clk_sys);
        rd_chk(rtc_pkg::A_TEMP_LO, 8'ha5);
        rd_chk(rtc_pkg::A_TEMP_HI, 8'h02);
    endtask : t_regs
    task automatic t_sel;
        int c;
        int e;
        for (int k = 1; k <= 4; k++) begin
            wr_reg(rtc_pkg::A_CTRL, 8'(k));
            count_edges(40, c);
            count_edges(128, c);
            e = 32 >> (k - 1);
            check("rate", 8'h01, 8'(c >= e-1 && c <= e+1));
        end
    endtask : t_sel
    task automatic t_irq;
        wr_reg(rtc_pkg::A_MASK, 8'h1a);
        wr_reg(rtc_pkg::A_VDD_TRIP, 8'h80);
        wr_reg(rtc_pkg::A_CTRL, 8'h00);
        pins(1'b0, 1'b1);
        vdd_level <= 8'h40;
        pins(1'b1, 1'b0);
        rd_chk(rtc_pkg::A_STAT, 8'h02);
        wr_reg(rtc_pkg::A_STAT, 8'h02);
        pins(1'b0, 1'b1);
        on_backup <= 1'b1;
        go <= 1'b1;
        pins(1'b1, 1'b0);
        rd_chk(rtc_pkg::A_STAT, 8'h00);
        repeat (140) @(posedge clk_sys);
        on_backup <= 1'b0;
        go <= 1'b0;
        pins(1'b1, 1'b0);
        rd_chk(rtc_pkg::A_BUS_STARTS, 8'h00);
        rd_chk(rtc_pkg::A_STAT, 8'h18);
        rd_chk(8'h20, 8'h12);
        rd_chk(8'h29, 8'h34);
        wr_reg(rtc_pkg::A_STAT, 8'h18);
        pins(1'b0, 1'b1);
        go <= 1'b1;
        repeat (140) @(posedge clk_sys);
        go <= 1'b0;
        rd_chk(rtc_pkg::A_BUS_STARTS, 8'h01);
    endtask : t_irq
    task automatic results;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        t_reset();
        t_regs();
        t_sel();
        t_irq();
        results();
    end
    initial begin
        #500000;
        num_errors++;
        results();
    end
endmodule : rtc_core_tb
